// ---- rtl/port_irq_loopback_pkg.sv ----
// Overview of operation
// (R01) Status bit 2 shows pending timestamp summary
// (R02) Status bit 1 shows pending PHY summary
// (R03) Status bit 0 sets on counter-mode filter event
// (R04) Filter status clears by toggling its mask bit
// (R05) Filter source exists on every port
// (R06) Mask bits inverted: zero enables, reset zero
// (R07) Timestamp mask gates only the summary bit
// (R08) Status holds only port-specific sources
// (R09) Mask decides which pending sources interrupt
// (R10) Bit 7 returns fabric egress to fabric
// (R11) Bit 6 returns line input to line
// (R12) PHY port loops receive pair to transmit
// (R13) MAC port loops transmit inputs to outputs
// (R14) Interrupt high while unmasked status bit set
// (R15) Reserved bits read zero; loopback resets zero
package port_irq_loopback_pkg;

  // ---------------------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS = 8'h1B;
  localparam logic [7:0] IDX_CLEAR  = 8'h1C;
  localparam logic [7:0] IDX_MASK   = 8'h1F;
  localparam logic [7:0] IDX_OPCTL  = 8'h20;
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);
  localparam logic [7:0] ADDR_CLEAR  = 8'(IDX_CLEAR * 4);
  localparam logic [7:0] ADDR_MASK   = 8'(IDX_MASK * 4);
  localparam logic [7:0] ADDR_OPCTL  = 8'(IDX_OPCTL * 4);

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int         BIT_PTP      = 2;
  localparam int         BIT_PHY      = 1;
  localparam int         BIT_ACL      = 0;
  localparam int         BIT_LOCAL_LB = 7;
  localparam int         BIT_REMOTE_LB = 6;
  localparam int         SRC_W        = 3;
  localparam logic [2:0] MASK_RESET   = 3'h0;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [1:0] LB_RESET     = 2'h0;

  // ---------------------------------------------------------------------------
  // Datapath modes
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_REMOTE = 2'b01,
    MODE_LOCAL  = 2'b10
  } lb_mode_t;

endpackage : port_irq_loopback_pkg

// ---- rtl/port_irq_loopback.sv ----
// The APB register port was decided locally.
`timescale 1ns/100ps
module port_irq_loopback
#(
  parameter int DATA_W  = 8,
  parameter bit HAS_PHY = 1'b1
)
(
  // Clock and reset
  input  wire logic                                    sys_clk,
  input  wire logic                                    rst_n,
  // APB slave
  input  wire logic                                    psel,
  input  wire logic                                    penable,
  input  wire logic                                    pwrite,
  input  wire logic [port_irq_loopback_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                             pwdata,
  output logic      [31:0]                             prdata,
  output logic                                         pready,
  output logic                                         pslverr,
  // Interrupt sources and request
  input  wire logic                                    ptp_summary,
  input  wire logic                                    phy_summary,
  input  wire logic                                    acl_count_event,
  output logic                                         irq,
  // Fabric side
  input  wire logic [DATA_W-1:0]                       fabric_tx_data,
  input  wire logic                                    fabric_tx_valid,
  output logic      [DATA_W-1:0]                       fabric_rx_data,
  output logic                                         fabric_rx_valid,
  // Line side (PHY pairs or external_mac_interface)
  input  wire logic [DATA_W-1:0]                       line_rx_data,
  input  wire logic                                    line_rx_valid,
  output logic      [DATA_W-1:0]                       line_tx_data,
  output logic                                         line_tx_valid
);
  import port_irq_loopback_pkg::*;

  generate
    if (DATA_W < 1)
    begin : g_bad_width
      $error("DATA_W must be at least 1.");
    end
    // The read path packs both loopback bits side by side, local above remote.
    if (BIT_LOCAL_LB != BIT_REMOTE_LB + 1)
    begin : g_bad_lb_pos
      $error("Loopback bits must be adjacent with local above remote.");
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ---------------------------------------------------------------------------
  // Register file and interrupt state
  // ---------------------------------------------------------------------------
  logic [SRC_W-1:0] status;
  logic [SRC_W-1:0] mask;
  logic [1:0]       lb;
  logic [SRC_W-1:0] next_status;
  logic [SRC_W-1:0] next_mask;
  logic [1:0]       next_lb;
  logic [31:0]      next_prdata;
  logic             next_pready;
  logic             next_pslverr;
  logic             next_irq;
  logic [SRC_W-1:0] src;
  logic [SRC_W-1:0] clr;
  logic             wr_commit;
  logic             mapped;

  always_comb
  begin
    // Sources a port does not have are tied off here so they never latch.
    src          = '0;
    src[BIT_PTP] = HAS_PHY & ptp_summary;       // R01
    src[BIT_PHY] = HAS_PHY & phy_summary;       // R02
    src[BIT_ACL] = acl_count_event;             // R03 R05 R08
    wr_commit    = psel & penable & pready & pwrite;
    mapped       = (paddr == ADDR_STATUS) || (paddr == ADDR_CLEAR) ||
                   (paddr == ADDR_MASK) || (paddr == ADDR_OPCTL);
    next_mask    = mask;
    next_lb      = lb;
    clr          = '0;
    if (wr_commit && paddr == ADDR_MASK)
    begin
      next_mask = pwdata[SRC_W-1:0];            // R06 R15
    end
    if (wr_commit && paddr == ADDR_OPCTL)
    begin
      next_lb = {pwdata[BIT_LOCAL_LB], pwdata[BIT_REMOTE_LB]}; // R10 R11
    end
    if (wr_commit && paddr == ADDR_CLEAR)
    begin
      clr[BIT_PTP] = pwdata[BIT_PTP];
      clr[BIT_PHY] = pwdata[BIT_PHY];
    end
    // The filter bit ignores the clear register and clears on a mask toggle.
    if (wr_commit && paddr == ADDR_MASK && (pwdata[BIT_ACL] != mask[BIT_ACL]))
    begin
      clr[BIT_ACL] = 1'b1;                      // R04
    end
    // A new event in the clearing cycle survives the clear.
    next_status  = (status & ~clr) | (src & ~mask); // R07 R09
    next_irq     = |(next_status & ~next_mask);     // R14
    next_pready  = psel & penable & ~pready;
    next_pslverr = psel & penable & ~pready & ~mapped;
    next_prdata  = '0;
    if (psel && penable && !pready && !pwrite)
    begin
      case (paddr)
        ADDR_STATUS: next_prdata = {29'h0000000, status};     // R15
        ADDR_MASK:   next_prdata = {29'h0000000, mask};
        ADDR_OPCTL:  next_prdata = {24'h000000, lb, 6'h00};
        default:     next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      status  <= STATUS_RESET;
      mask    <= MASK_RESET;                    // R06
      lb      <= LB_RESET;                      // R15
      irq     <= 1'b0;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      status  <= next_status;
      mask    <= next_mask;
      lb      <= next_lb;
      irq     <= next_irq;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ---------------------------------------------------------------------------
  // Loopback datapath
  // ---------------------------------------------------------------------------
  lb_mode_t          mode;
  logic [DATA_W-1:0] next_fabric_rx_data;
  logic              next_fabric_rx_valid;
  logic [DATA_W-1:0] next_line_tx_data;
  logic              next_line_tx_valid;

  always_comb
  begin
    // Local loopback wins when both bits are set; remote traffic then idles.
    if (lb[1])
    begin
      mode = MODE_LOCAL;
    end
    else if (lb[0])
    begin
      mode = MODE_REMOTE;
    end
    else
    begin
      mode = MODE_NORMAL;
    end
    next_fabric_rx_data  = line_rx_data;
    next_fabric_rx_valid = line_rx_valid;
    next_line_tx_data    = fabric_tx_data;
    next_line_tx_valid   = fabric_tx_valid;
    case (mode)
      MODE_LOCAL:
      begin
        next_fabric_rx_data  = fabric_tx_data;  // R10
        next_fabric_rx_valid = fabric_tx_valid;
        next_line_tx_data    = '0;
        next_line_tx_valid   = 1'b0;
      end
      MODE_REMOTE:
      begin
        next_line_tx_data    = line_rx_data;    // R11 R12 R13
        next_line_tx_valid   = line_rx_valid;
        next_fabric_rx_data  = '0;
        next_fabric_rx_valid = 1'b0;
      end
      MODE_NORMAL:
      begin
        next_fabric_rx_valid = line_rx_valid;
      end
      default:
      begin
        next_fabric_rx_valid = 1'b0;
        next_line_tx_valid   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      fabric_rx_data  <= '0;
      fabric_rx_valid <= 1'b0;
      line_tx_data    <= '0;
      line_tx_valid   <= 1'b0;
    end
    else
    begin
      fabric_rx_data  <= next_fabric_rx_data;
      fabric_rx_valid <= next_fabric_rx_valid;
      line_tx_data    <= next_line_tx_data;
      line_tx_valid   <= next_line_tx_valid;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_n);

  property p_ptp_absent;
    !HAS_PHY |-> !status[BIT_PTP];
  endproperty
  a_ptp_absent: assert property (p_ptp_absent) // R01
    else $error("Timestamp status set on a port without PHY.");

  property p_phy_set;
    (HAS_PHY && phy_summary && !mask[BIT_PHY]) |=> status[BIT_PHY];
  endproperty
  a_phy_set: assert property (p_phy_set) // R02
    else $error("PHY status did not latch an enabled summary.");

  property p_acl_set;
    (acl_count_event && !mask[BIT_ACL]) |=> status[BIT_ACL];
  endproperty
  a_acl_set: assert property (p_acl_set) // R03
    else $error("Filter status did not set on an enabled event.");

  property p_acl_hold;
    (status[BIT_ACL] && !(wr_commit && paddr == ADDR_MASK)) |=> status[BIT_ACL];
  endproperty
  a_acl_hold: assert property (p_acl_hold) // R04
    else $error("Filter status cleared without a mask write.");

  property p_acl_toggle;
    (wr_commit && paddr == ADDR_MASK && pwdata[BIT_ACL] != mask[BIT_ACL]
     && !acl_count_event) |=> !status[BIT_ACL];
  endproperty
  a_acl_toggle: assert property (p_acl_toggle) // R04
    else $error("Mask toggle did not clear filter status.");

  property p_masked_no_set;
    (!status[BIT_PHY] && mask[BIT_PHY]) |=> !status[BIT_PHY];
  endproperty
  a_masked_no_set: assert property (p_masked_no_set) // R09
    else $error("Disabled source set its status bit.");

  property p_irq_level;
    irq == |(status & ~mask);
  endproperty
  a_irq_level: assert property (p_irq_level) // R14
    else $error("Interrupt does not follow unmasked status.");

  property p_local_lb;
    (lb[1] && fabric_tx_valid) |=> (fabric_rx_valid && !line_tx_valid);
  endproperty
  a_local_lb: assert property (p_local_lb) // R10
    else $error("Local loopback did not return fabric data.");

  property p_remote_lb;
    (lb == 2'b01) |=> (line_tx_data == $past(line_rx_data) && !fabric_rx_valid);
  endproperty
  a_remote_lb: assert property (p_remote_lb) // R11
    else $error("Remote loopback did not return line data.");

  property p_reserved_zero;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R15
    else $error("Reserved read bits not zero.");

  property p_ready_one;
    (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("Ready did not answer in one wait cycle.");

  property p_status_ro;
    (wr_commit && paddr == ADDR_STATUS && !(|src)) |=> status == $past(status);
  endproperty
  a_status_ro: assert property (p_status_ro) // R04
    else $error("Status register changed on a write to it.");

  property p_ptp_masked;
    (!status[BIT_PTP] && mask[BIT_PTP]) |=> !status[BIT_PTP];
  endproperty
  a_ptp_masked: assert property (p_ptp_masked) // R07
    else $error("Disabled timestamp summary set its status bit.");

  property p_clear_summary;
    (wr_commit && paddr == ADDR_CLEAR && pwdata[BIT_PHY] && !src[BIT_PHY])
      |=> !status[BIT_PHY];
  endproperty
  a_clear_summary: assert property (p_clear_summary)
    else $error("Clear register did not clear the PHY status bit.");

  property p_both_local;
    (lb == 2'b11 && line_rx_valid) |=>
      (!line_tx_valid && fabric_rx_valid == $past(fabric_tx_valid));
  endproperty
  a_both_local: assert property (p_both_local) // R10
    else $error("Local loopback did not win over remote.");

  // The reset term keeps the first edge after release, when outputs still show reset, out.
  property p_normal_path;
    (lb == 2'b00 && rst_sync_n) |=>
      (line_tx_data == $past(fabric_tx_data) && fabric_rx_data == $past(line_rx_data));
  endproperty
  a_normal_path: assert property (p_normal_path) // R10 R11
    else $error("Normal operation did not pass data straight through.");

  property p_unmapped_err;
    (psel && penable && !pready && !mapped) |=> (pslverr && prdata == 32'h00000000);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("Unmapped access did not report an error.");

  c_acl_clear: cover property (status[BIT_ACL] ##1 !status[BIT_ACL]);
  c_irq_rise:  cover property (!irq ##1 irq);
  c_local:     cover property (lb[1] && fabric_rx_valid);
  c_remote:    cover property (lb == 2'b01 && line_tx_valid);
  c_unmapped:  cover property (pslverr);

endmodule : port_irq_loopback

// ---- tb/line_peer_model.sv ----
`timescale 1ns/100ps
module line_peer_model
(
  // Clock
  input  wire logic       sys_clk,
  // Request from the bench
  input  wire logic       send,
  input  wire logic [7:0] data_in,
  // Pins toward the port
  output logic      [7:0] line_rx_data,
  output logic            line_rx_valid
);
  logic [7:0] data_q  = 8'h00;
  logic       valid_q = 1'b0;

  // Idle data is inverted every cycle so a stale word never passes for a fresh one.
  always @(posedge sys_clk)
  begin
    valid_q <= send;
    data_q  <= send ? data_in : ~data_q;
  end

  assign line_rx_data  = data_q;
  assign line_rx_valid = valid_q;
endmodule : line_peer_model

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import port_irq_loopback_pkg::*;
  logic              sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              ptp_summary, phy_summary, acl_count_event, irq, send;
  logic [7:0]        fabric_tx_data, fabric_rx_data, line_rx_data, line_tx_data, pkt;
  logic              fabric_tx_valid, fabric_rx_valid, line_rx_valid, line_tx_valid;
  int                fail_count, checks_done;
  logic [31:0]       mac_prdata, mac_rd;
  logic [7:0]        mac_line_tx_data;
  logic              mac_irq, mac_line_tx_valid;

  port_irq_loopback dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ptp_summary(ptp_summary),
    .phy_summary(phy_summary), .acl_count_event(acl_count_event), .irq(irq),
    .fabric_tx_data(fabric_tx_data), .fabric_tx_valid(fabric_tx_valid),
    .fabric_rx_data(fabric_rx_data), .fabric_rx_valid(fabric_rx_valid),
    .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
    .line_tx_data(line_tx_data), .line_tx_valid(line_tx_valid));

  // The external MAC port copy shares every input, so one bus cycle reaches both ports.
  port_irq_loopback #(.DATA_W(8), .HAS_PHY(1'b0)) mac_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(mac_prdata), .pready(), .pslverr(), .ptp_summary(ptp_summary),
    .phy_summary(phy_summary), .acl_count_event(acl_count_event), .irq(mac_irq),
    .fabric_tx_data(fabric_tx_data), .fabric_tx_valid(fabric_tx_valid),
    .fabric_rx_data(), .fabric_rx_valid(),
    .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
    .line_tx_data(mac_line_tx_data), .line_tx_valid(mac_line_tx_valid));

  line_peer_model peer_u (.sys_clk(sys_clk), .send(send), .data_in(pkt),
    .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The slave is waited for under a bound; it never stalls the run for ever.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      fail_count++;
      report_and_stop();
    end
    rd  = prdata;
    mac_rd = mac_prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk

  task automatic after(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : after

  // The line word goes one cycle ahead of the fabric word, so both reach the outputs at once.
  task automatic drive_both(input logic [7:0] line_d, input logic [7:0] fab_d);
    pkt  <= line_d;
    send <= 1'b1;
    @(posedge sys_clk);
    send            <= 1'b0;
    fabric_tx_data  <= fab_d;
    fabric_tx_valid <= 1'b1;
    @(posedge sys_clk);
    fabric_tx_valid <= 1'b0;
    @(posedge sys_clk);
  endtask : drive_both

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    {rst_n, psel, penable, pwrite, send, ptp_summary, phy_summary} = 7'h00;
    {acl_count_event, fabric_tx_valid} = 2'h0;
    {paddr, pwdata, fabric_tx_data, pkt} = 56'h0;
    fail_count = 0;
    checks_done = 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_chk(ADDR_STATUS, 32'h0);
    rd_chk(ADDR_MASK, 32'h0);
    rd_chk(ADDR_OPCTL, 32'h0);
    apb(1'b1, ADDR_MASK, 32'hFF);
    rd_chk(ADDR_MASK, 32'h07);
    apb(1'b1, ADDR_MASK, 32'h00);
    apb(1'b0, 8'h04, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset and map done");

    acl_count_event <= 1'b1;
    @(posedge sys_clk);
    acl_count_event <= 1'b0;
    after(2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_STATUS, 32'h0);
    rd_chk(ADDR_STATUS, 32'h01);
    chk(mac_rd, 32'h01);
    apb(1'b1, ADDR_CLEAR, 32'h07);
    rd_chk(ADDR_STATUS, 32'h01);
    apb(1'b1, ADDR_MASK, 32'h01);
    apb(1'b1, ADDR_MASK, 32'h00);
    rd_chk(ADDR_STATUS, 32'h00);
    after(2);
    chk({31'h0, irq}, 32'h0);
    $display("test filter event done");

    ptp_summary <= 1'b1;
    phy_summary <= 1'b1;
    after(3);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, mac_irq}, 32'h0);
    rd_chk(ADDR_STATUS, 32'h06);
    chk(mac_rd, 32'h00);
    ptp_summary <= 1'b0;
    phy_summary <= 1'b0;
    apb(1'b1, ADDR_CLEAR, 32'h06);
    rd_chk(ADDR_STATUS, 32'h00);
    apb(1'b1, ADDR_MASK, 32'h07);
    {ptp_summary, phy_summary, acl_count_event} <= 3'h7;
    after(3);
    {ptp_summary, phy_summary, acl_count_event} <= 3'h0;
    chk({31'h0, irq}, 32'h0);
    rd_chk(ADDR_STATUS, 32'h00);
    apb(1'b1, ADDR_MASK, 32'h00);
    $display("test summary sources done");

    apb(1'b1, ADDR_OPCTL, 32'h40);
    drive_both(8'h3C, 8'h5A);
    chk({23'h0, line_tx_valid, line_tx_data}, 32'h13C);
    chk({31'h0, fabric_rx_valid}, 32'h0);
    chk({23'h0, mac_line_tx_valid, mac_line_tx_data}, 32'h13C);
    apb(1'b1, ADDR_OPCTL, 32'h80);
    rd_chk(ADDR_OPCTL, 32'h80);
    drive_both(8'h66, 8'hA5);
    chk({23'h0, fabric_rx_valid, fabric_rx_data}, 32'h1A5);
    chk({31'h0, line_tx_valid}, 32'h0);
    apb(1'b1, ADDR_OPCTL, 32'hC0);
    drive_both(8'h99, 8'hC3);
    chk({23'h0, fabric_rx_valid, fabric_rx_data}, 32'h1C3);
    chk({31'h0, line_tx_valid}, 32'h0);
    $display("test loopback done");

    apb(1'b1, ADDR_MASK, 32'h06);
    fabric_tx_valid <= 1'b1;
    rst_n           <= 1'b0;
    after(2);
    chk({31'h0, fabric_rx_valid}, 32'h0);
    fabric_tx_valid <= 1'b0;
    rst_n           <= 1'b1;
    after(3);
    rd_chk(ADDR_MASK, 32'h00);
    rd_chk(ADDR_OPCTL, 32'h00);
    drive_both(8'h24, 8'h81);
    chk({23'h0, fabric_rx_valid, fabric_rx_data}, 32'h124);
    chk({23'h0, line_tx_valid, line_tx_data}, 32'h181);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : testbench
